// >>> design/balu_pkg.sv
// package: operation codes, flag positions, timing counts for the byte alu
// ****************************************
// Functional notes
// ****************************************
// Functional notes
// [RULE_01] add and add-with-carry write d+s(+c), update z c n v h, one clock
// [RULE_02] word add immediate adds constant to 16-bit pair, z c n v s, two clocks
// [RULE_03] subtract register or constant writes d-s, z c n v h, one clock
// [RULE_04] subtract with carry register writes d-s-c, z c n v h, one clock
// [RULE_05] subtract with carry constant writes d-k-c, z c n v h, one clock
// [RULE_06] word subtract immediate subtracts constant from pair, z c n v s, two clocks
// [RULE_07] and with register or constant writes result, z n v only, one clock
// [RULE_08] or with register or constant writes result, z n v only, one clock
// [RULE_09] exclusive or writes d^s, z n v only, one clock
// [RULE_10] complement writes 0xFF-d, z c n v, one clock
// [RULE_11] set mask ors constant into d, z n v, one clock
// [RULE_12] clear mask ands d with inverse constant, z n v, one clock
// [RULE_13] test ands register with itself, z n v from value, one clock
// [RULE_14] clear register xors with itself to zero, z n v, one clock
// [RULE_15] flags not affected by an operation keep their prior values
package balu_pkg;
    typedef enum logic [4:0] {
        BALU_OP_ADD,
        BALU_OP_ADD_CARRY,
        BALU_OP_WORD_ADD_IMM,
        BALU_OP_SUB,
        BALU_OP_SUB_CONST,
        BALU_OP_SUB_CARRY,
        BALU_OP_SUB_CARRY_CONST,
        BALU_OP_WORD_SUB_IMM,
        BALU_OP_AND,
        BALU_OP_AND_CONST,
        BALU_OP_OR,
        BALU_OP_OR_CONST,
        BALU_OP_XOR,
        BALU_OP_COM,
        BALU_OP_SET_MASK,
        BALU_OP_CLEAR_MASK,
        BALU_OP_TEST,
        BALU_OP_ZERO_REG
    } balu_op_t;
    // flag positions in the status byte
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam int unsigned BYTE_CYCLES = 1;
    localparam int unsigned WORD_CYCLES = 2;
endpackage

// >>> design/balu_core.sv
// combinational byte arithmetic: sum or difference with carry, half carry, overflow
`timescale 1ns/1ps
module balu_core (
    // operands
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic cin_i,
    input wire logic sub_i,
    // results
    output logic [7:0] res_o,
    output logic c_o,
    output logic h_o,
    output logic v_o
);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] bx;
    always_comb
    begin
        // subtract as a + ~b + ~borrow so one adder serves both
        bx = sub_i ? ~b_i : b_i;
        full = {1'b0, a_i} + {1'b0, bx} + {8'h00, cin_i ^ sub_i};
        low = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin_i ^ sub_i};
        res_o = full[7:0];
        c_o = full[8] ^ sub_i;
        h_o = low[4] ^ sub_i;
        v_o = (a_i[7] == bx[7]) && (full[7] != a_i[7]);
    end
endmodule

// >>> design/balu_top.sv
// byte alu: executes one arithmetic or logic operation and holds result and flags
`timescale 1ns/1ps
module balu_top (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // request from decoder
    input wire logic START_I,
    input wire balu_pkg::balu_op_t OP_I,
    input wire logic [7:0] DEST_I,
    input wire logic [7:0] DEST_HIGH_I,
    input wire logic [7:0] SOURCE_OPERAND_I,
    input wire logic [7:0] FLAGS_I,
    // answer to register file
    output logic BUSY_O,
    output logic DONE_O,
    output logic WRITE_HIGH_O,
    output logic [7:0] RESULT_O,
    output logic [7:0] RESULT_HIGH_O,
    output logic [7:0] FLAGS_O
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic {BALU_IDLE, BALU_WORD2} balu_state_t;
    balu_state_t state_q, state_d;
    logic done_q, done_d;
    logic whigh_q, whigh_d;
    logic [7:0] res_q, res_d;
    logic [7:0] resh_q, resh_d;
    logic [7:0] flags_q, flags_d;
    logic [7:0] wlo_q, wlo_d;
    logic wc_q, wc_d;
    balu_pkg::balu_op_t op_q, op_d;

    // shared adder
    logic [7:0] add_a, add_b, add_r;
    logic add_cin, add_sub, add_c, add_h, add_v;

    balu_core u_core (
        .a_i(add_a),
        .b_i(add_b),
        .cin_i(add_cin),
        .sub_i(add_sub),
        .res_o(add_r),
        .c_o(add_c),
        .h_o(add_h),
        .v_o(add_v)
    );

    function automatic logic is_word(input balu_pkg::balu_op_t op);
        is_word = (op == balu_pkg::BALU_OP_WORD_ADD_IMM) ||
            (op == balu_pkg::BALU_OP_WORD_SUB_IMM);
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [7:0] lr;
        lr = 8'h00;
        state_d = state_q;
        done_d = 1'b0;
        whigh_d = 1'b0;
        res_d = res_q;
        resh_d = resh_q;
        flags_d = flags_q;
        wlo_d = wlo_q;
        wc_d = wc_q;
        op_d = op_q;
        add_a = DEST_I;
        add_b = SOURCE_OPERAND_I;
        add_cin = 1'b0;
        add_sub = 1'b0;
        unique case (state_q)
            BALU_IDLE:
            begin
                if (START_I)
                begin
                    // [RULE_15] keep unaffected flags
                    flags_d = FLAGS_I;
                    op_d = OP_I;
                    unique case (OP_I)
                        // [RULE_01] add forms
                        balu_pkg::BALU_OP_ADD, balu_pkg::BALU_OP_ADD_CARRY,
                        // [RULE_03] subtract forms
                        balu_pkg::BALU_OP_SUB, balu_pkg::BALU_OP_SUB_CONST,
                        // [RULE_04] subtract with carry
                        balu_pkg::BALU_OP_SUB_CARRY,
                        // [RULE_05] subtract carry constant
                        balu_pkg::BALU_OP_SUB_CARRY_CONST:
                        begin
                            add_sub = (OP_I != balu_pkg::BALU_OP_ADD) &&
                                (OP_I != balu_pkg::BALU_OP_ADD_CARRY);
                            add_cin = ((OP_I == balu_pkg::BALU_OP_ADD_CARRY) ||
                                (OP_I == balu_pkg::BALU_OP_SUB_CARRY) ||
                                (OP_I == balu_pkg::BALU_OP_SUB_CARRY_CONST)) &&
                                FLAGS_I[balu_pkg::FLAG_C];
                            lr = add_r;
                            flags_d[balu_pkg::FLAG_C] = add_c;
                            flags_d[balu_pkg::FLAG_H] = add_h;
                            flags_d[balu_pkg::FLAG_V] = add_v;
                        end
                        // [RULE_02] word add low byte
                        // [RULE_06] word subtract low byte
                        balu_pkg::BALU_OP_WORD_ADD_IMM, balu_pkg::BALU_OP_WORD_SUB_IMM:
                        begin
                            add_sub = (OP_I == balu_pkg::BALU_OP_WORD_SUB_IMM);
                            lr = add_r;
                        end
                        // [RULE_07] and
                        balu_pkg::BALU_OP_AND, balu_pkg::BALU_OP_AND_CONST:
                        begin
                            lr = DEST_I & SOURCE_OPERAND_I;
                            flags_d[balu_pkg::FLAG_V] = 1'b0;
                        end
                        // [RULE_08] or
                        // [RULE_11] set mask
                        balu_pkg::BALU_OP_OR, balu_pkg::BALU_OP_OR_CONST,
                        balu_pkg::BALU_OP_SET_MASK:
                        begin
                            lr = DEST_I | SOURCE_OPERAND_I;
                            flags_d[balu_pkg::FLAG_V] = 1'b0;
                        end
                        // [RULE_09] exclusive or
                        balu_pkg::BALU_OP_XOR:
                        begin
                            lr = DEST_I ^ SOURCE_OPERAND_I;
                            flags_d[balu_pkg::FLAG_V] = 1'b0;
                        end
                        // [RULE_10] complement
                        balu_pkg::BALU_OP_COM:
                        begin
                            lr = balu_pkg::ALL_ONES - DEST_I;
                            flags_d[balu_pkg::FLAG_C] = 1'b1;
                            flags_d[balu_pkg::FLAG_V] = 1'b0;
                        end
                        // [RULE_12] clear mask
                        balu_pkg::BALU_OP_CLEAR_MASK:
                        begin
                            lr = DEST_I & (balu_pkg::ALL_ONES - SOURCE_OPERAND_I);
                            flags_d[balu_pkg::FLAG_V] = 1'b0;
                        end
                        // [RULE_13] test
                        balu_pkg::BALU_OP_TEST:
                        begin
                            lr = DEST_I & DEST_I;
                            flags_d[balu_pkg::FLAG_V] = 1'b0;
                        end
                        // [RULE_14] clear register
                        balu_pkg::BALU_OP_ZERO_REG:
                        begin
                            lr = DEST_I ^ DEST_I;
                            flags_d[balu_pkg::FLAG_V] = 1'b0;
                        end
                        default:
                        begin
                            lr = DEST_I;
                        end
                    endcase
                    res_d = lr;
                    if (is_word(OP_I))
                    begin
                        // high byte next cycle: the adder is shared, trading a cycle for area
                        wlo_d = lr;
                        wc_d = add_c;
                        state_d = BALU_WORD2;
                    end
                    else
                    begin
                        flags_d[balu_pkg::FLAG_Z] = (lr == 8'h00);
                        flags_d[balu_pkg::FLAG_N] = lr[7];
                        done_d = 1'b1;
                    end
                end
            end
            BALU_WORD2:
            begin
                // [RULE_02] high byte with carry
                // [RULE_06] high byte with borrow
                add_a = DEST_HIGH_I;
                add_b = 8'h00;
                add_sub = (op_q == balu_pkg::BALU_OP_WORD_SUB_IMM);
                add_cin = wc_q;
                resh_d = add_r;
                flags_d[balu_pkg::FLAG_C] = add_c;
                flags_d[balu_pkg::FLAG_Z] = ({add_r, wlo_q} == 16'h0000);
                flags_d[balu_pkg::FLAG_N] = add_r[7];
                flags_d[balu_pkg::FLAG_V] = add_v;
                flags_d[balu_pkg::FLAG_S] = add_r[7] ^ add_v;
                whigh_d = 1'b1;
                done_d = 1'b1;
                state_d = BALU_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_q <= BALU_IDLE;
            done_q <= 1'b0;
            whigh_q <= 1'b0;
            res_q <= balu_pkg::RESULT_RESET;
            resh_q <= balu_pkg::RESULT_RESET;
            flags_q <= balu_pkg::FLAGS_RESET;
            wlo_q <= 8'h00;
            wc_q <= 1'b0;
            op_q <= balu_pkg::BALU_OP_ADD;
        end
        else
        begin
            state_q <= state_d;
            done_q <= done_d;
            whigh_q <= whigh_d;
            res_q <= res_d;
            resh_q <= resh_d;
            flags_q <= flags_d;
            wlo_q <= wlo_d;
            wc_q <= wc_d;
            op_q <= op_d;
        end
    end

    assign BUSY_O = (state_q != BALU_IDLE);
    assign DONE_O = done_q;
    assign WRITE_HIGH_O = whigh_q;
    assign RESULT_O = res_q;
    assign RESULT_HIGH_O = resh_q;
    assign FLAGS_O = flags_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_byte_done_time: assert property ( // [RULE_01]
        START_I && !BUSY_O && !is_word(OP_I) |=> DONE_O && !WRITE_HIGH_O)
        else $error("byte operation did not finish in one clock");
    a_word_done_time: assert property ( // [RULE_02]
        START_I && !BUSY_O && is_word(OP_I) |=> !DONE_O ##1 DONE_O && WRITE_HIGH_O)
        else $error("word operation did not finish in two clocks");
    a_add_result: assert property ( // [RULE_01]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_ADD
        |=> RESULT_O == 8'($past(DEST_I) + $past(SOURCE_OPERAND_I)))
        else $error("add result wrong");
    a_sub_result: assert property ( // [RULE_03]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_SUB
        |=> RESULT_O == 8'($past(DEST_I) - $past(SOURCE_OPERAND_I)))
        else $error("subtract result wrong");
    a_sub_carry_result: assert property ( // [RULE_04]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_SUB_CARRY
        |=> RESULT_O == 8'($past(DEST_I) - $past(SOURCE_OPERAND_I)
            - {7'h00, $past(FLAGS_I[balu_pkg::FLAG_C])}))
        else $error("subtract with carry result wrong");
    a_com_flags: assert property ( // [RULE_10]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_COM
        |=> FLAGS_O[balu_pkg::FLAG_C] && !FLAGS_O[balu_pkg::FLAG_V])
        else $error("complement flags wrong");
    a_zero_reg: assert property ( // [RULE_14]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_ZERO_REG
        |=> RESULT_O == 8'h00 && FLAGS_O[balu_pkg::FLAG_Z])
        else $error("clear register wrong");
    a_logic_keep: assert property ( // [RULE_15]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_AND
        |=> FLAGS_O[balu_pkg::FLAG_C] == $past(FLAGS_I[balu_pkg::FLAG_C])
            && FLAGS_O[balu_pkg::FLAG_H] == $past(FLAGS_I[balu_pkg::FLAG_H]))
        else $error("unaffected flag changed");
    a_sub_carry_const: assert property ( // [RULE_05]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_SUB_CARRY_CONST
        |=> RESULT_O == 8'($past(DEST_I) - $past(SOURCE_OPERAND_I)
            - {7'h00, $past(FLAGS_I[balu_pkg::FLAG_C])}))
        else $error("subtract with carry constant result wrong");
    a_xor_result: assert property ( // [RULE_09]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_XOR
        |=> RESULT_O == ($past(DEST_I) ^ $past(SOURCE_OPERAND_I))
            && !FLAGS_O[balu_pkg::FLAG_V])
        else $error("exclusive or result wrong");
    a_clear_mask: assert property ( // [RULE_12]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_CLEAR_MASK
        |=> RESULT_O == ($past(DEST_I) & ~$past(SOURCE_OPERAND_I)))
        else $error("clear mask result wrong");
    a_test_flags: assert property ( // [RULE_13]
        START_I && !BUSY_O && OP_I == balu_pkg::BALU_OP_TEST
        |=> RESULT_O == $past(DEST_I) && FLAGS_O[balu_pkg::FLAG_N] == RESULT_O[7]
            && !FLAGS_O[balu_pkg::FLAG_V])
        else $error("test flags wrong");
    a_word_keep_half: assert property ( // [RULE_15]
        START_I && !BUSY_O && is_word(OP_I)
        |=> ##1 FLAGS_O[balu_pkg::FLAG_H] == $past(FLAGS_I[balu_pkg::FLAG_H], 2))
        else $error("word operation changed half carry");
    a_busy_one_cycle: assert property ( // [RULE_02]
        BUSY_O |=> !BUSY_O)
        else $error("busy held longer than one cycle");
    c_word_add: cover property (START_I && OP_I == balu_pkg::BALU_OP_WORD_ADD_IMM ##2 DONE_O);
    c_word_sub: cover property (START_I && OP_I == balu_pkg::BALU_OP_WORD_SUB_IMM ##2 DONE_O);
    c_carry_out: cover property (DONE_O && FLAGS_O[balu_pkg::FLAG_C]);
    c_refused: cover property (START_I && BUSY_O);
    c_back_to_back: cover property (DONE_O && START_I && !BUSY_O ##1 DONE_O);
endmodule

// >>> test/balu_regfile_model.sv
// register file model: supplies the high byte of a pair for word operations
`timescale 1ns/1ps
module balu_regfile_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // view of the request
    input wire logic start_i,
    input wire logic busy_i,
    input wire balu_pkg::balu_op_t op_i,
    input wire logic [7:0] high_value_i,
    // high byte to the alu
    output logic [7:0] dest_high_o
);
    logic word_q;
    logic [7:0] junk_q;
    // high byte only valid in the cycle after a taken word request
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            word_q <= 1'b0;
            junk_q <= 8'hA5;
        end
        else
        begin
            word_q <= start_i && !busy_i && (op_i == balu_pkg::BALU_OP_WORD_ADD_IMM
                || op_i == balu_pkg::BALU_OP_WORD_SUB_IMM);
            junk_q <= ~junk_q;
        end
    end
    // outside that cycle a changing pattern, so a late sample cannot pass by luck
    assign dest_high_o = word_q ? high_value_i : junk_q;
endmodule

// >>> test/testbench.sv
// self-checking bench for the byte alu
`timescale 1ns/1ps
module testbench;
    logic SYS_CLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic START_I = 1'b0;
    balu_pkg::balu_op_t OP_I = balu_pkg::BALU_OP_ADD;
    logic [7:0] DEST_I = 8'h00;
    logic [7:0] DEST_HIGH_I;
    logic [7:0] SOURCE_OPERAND_I = 8'h00;
    logic [7:0] FLAGS_I = 8'h00;
    logic [7:0] high_value = 8'h00;
    logic BUSY_O, DONE_O, WRITE_HIGH_O;
    logic [7:0] RESULT_O, RESULT_HIGH_O, FLAGS_O;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    always #10 SYS_CLK_I = ~SYS_CLK_I;
    balu_top u_dut (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .START_I(START_I), .OP_I(OP_I),
        .DEST_I(DEST_I), .DEST_HIGH_I(DEST_HIGH_I), .SOURCE_OPERAND_I(SOURCE_OPERAND_I),
        .FLAGS_I(FLAGS_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .WRITE_HIGH_O(WRITE_HIGH_O),
        .RESULT_O(RESULT_O), .RESULT_HIGH_O(RESULT_HIGH_O), .FLAGS_O(FLAGS_O));
    balu_regfile_model u_regfile (.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I), .start_i(START_I),
        .busy_i(BUSY_O), .op_i(OP_I), .high_value_i(high_value), .dest_high_o(DEST_HIGH_I));
    // ****************************************
    // helpers
    // ****************************************
    task automatic end_sim();
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // a hang is cut short well beyond the 48 cycles the run needs
    always @(posedge SYS_CLK_I)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // reference: returns high byte, low byte and new status byte
    function automatic logic [23:0] ref_calc(input balu_pkg::balu_op_t op,
        input logic [7:0] d, input logic [7:0] dh, input logic [7:0] s, input logic [7:0] f);
        logic [8:0] r;
        logic [16:0] w;
        logic [7:0] fo;
        logic [4:0] h5;
        logic cin;
        fo = f;
        cin = f[0] && (op == balu_pkg::BALU_OP_ADD_CARRY || op == balu_pkg::BALU_OP_SUB_CARRY
            || op == balu_pkg::BALU_OP_SUB_CARRY_CONST);
        r = {1'b0, d};
        fo[3] = 1'b0;
        case (op)
            balu_pkg::BALU_OP_ADD, balu_pkg::BALU_OP_ADD_CARRY:
            begin
                r = d + s + cin;
                h5 = d[3:0] + s[3:0] + cin;
                fo[5] = h5[4];
                fo[3] = (d[7] == s[7]) && (r[7] != d[7]);
                fo[0] = r[8];
            end
            balu_pkg::BALU_OP_SUB, balu_pkg::BALU_OP_SUB_CONST, balu_pkg::BALU_OP_SUB_CARRY,
            balu_pkg::BALU_OP_SUB_CARRY_CONST:
            begin
                r = {1'b0, d} - s - cin;
                h5 = {1'b0, d[3:0]} - s[3:0] - cin;
                fo[5] = h5[4];
                fo[3] = (d[7] != s[7]) && (r[7] != d[7]);
                fo[0] = r[8];
            end
            balu_pkg::BALU_OP_WORD_ADD_IMM, balu_pkg::BALU_OP_WORD_SUB_IMM:
            begin
                if (op == balu_pkg::BALU_OP_WORD_ADD_IMM)
                    w = {dh, d} + s;
                else
                    w = {1'b0, dh, d} - s;
                fo[0] = w[16];
                fo[1] = (w[15:0] == 16'h0000);
                fo[2] = w[15];
                fo[3] = (op == balu_pkg::BALU_OP_WORD_ADD_IMM) ? (!dh[7] && w[15])
                    : (dh[7] && !w[15]);
                fo[4] = fo[2] ^ fo[3];
                return {w[15:0], fo};
            end
            balu_pkg::BALU_OP_AND, balu_pkg::BALU_OP_AND_CONST: r[7:0] = d & s;
            balu_pkg::BALU_OP_OR, balu_pkg::BALU_OP_OR_CONST, balu_pkg::BALU_OP_SET_MASK:
                r[7:0] = d | s;
            balu_pkg::BALU_OP_XOR: r[7:0] = d ^ s;
            balu_pkg::BALU_OP_CLEAR_MASK: r[7:0] = d & (8'hFF - s);
            balu_pkg::BALU_OP_ZERO_REG: r[7:0] = 8'h00;
            balu_pkg::BALU_OP_COM:
            begin
                r[7:0] = 8'hFF - d;
                fo[0] = 1'b1;
            end
            default: r[7:0] = d;
        endcase
        fo[1] = (r[7:0] == 8'h00);
        fo[2] = r[7];
        return {8'h00, r[7:0], fo};
    endfunction
    // one request at a negedge; a byte request leaves the strobe up for back-to-back use
    task automatic issue(input balu_pkg::balu_op_t op, input logic [7:0] d, input logic [7:0] dh,
        input logic [7:0] s, input logic [7:0] f, input logic poke);
        logic [23:0] e;
        e = ref_calc(op, d, dh, s, f);
        START_I = 1'b1;
        OP_I = op;
        DEST_I = d;
        SOURCE_OPERAND_I = s;
        FLAGS_I = f;
        high_value = dh;
        @(negedge SYS_CLK_I);
        if (op == balu_pkg::BALU_OP_WORD_ADD_IMM || op == balu_pkg::BALU_OP_WORD_SUB_IMM)
        begin
            // operands change after the request edge; a refused poke rides in the busy cycle
            START_I = poke;
            OP_I = balu_pkg::BALU_OP_ZERO_REG;
            DEST_I = ~d;
            SOURCE_OPERAND_I = ~s;
            FLAGS_I = ~f;
            chk({6'h00, BUSY_O, DONE_O}, 8'h02);
            chk(RESULT_O, e[15:8]);
            @(negedge SYS_CLK_I);
            START_I = 1'b0;
            chk({5'h00, BUSY_O, DONE_O, WRITE_HIGH_O}, 8'h03);
            chk(RESULT_HIGH_O, e[23:16]);
        end
        else
            chk({5'h00, BUSY_O, DONE_O, WRITE_HIGH_O}, 8'h02);
        chk(RESULT_O, e[15:8]);
        chk(FLAGS_O, e[7:0]);
    endtask
    task automatic idle();
        START_I = 1'b0;
        @(negedge SYS_CLK_I);
        chk({7'h00, DONE_O}, 8'h00);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_add();
        issue(balu_pkg::BALU_OP_ADD, 8'h0F, 8'h00, 8'h01, 8'h10, 1'b0);
        issue(balu_pkg::BALU_OP_ADD, 8'h7F, 8'h00, 8'h01, 8'h00, 1'b0);
        issue(balu_pkg::BALU_OP_ADD, 8'hFF, 8'h00, 8'h01, 8'hD0, 1'b0);
        issue(balu_pkg::BALU_OP_ADD_CARRY, 8'h18, 8'h00, 8'h27, 8'h01, 1'b0);
        idle();
    endtask
    task automatic t_sub();
        issue(balu_pkg::BALU_OP_SUB, 8'h00, 8'h00, 8'h01, 8'h10, 1'b0);
        issue(balu_pkg::BALU_OP_SUB_CONST, 8'h80, 8'h00, 8'h01, 8'h00, 1'b0);
        issue(balu_pkg::BALU_OP_SUB_CARRY, 8'h20, 8'h00, 8'h0F, 8'h01, 1'b0);
        issue(balu_pkg::BALU_OP_SUB_CARRY_CONST, 8'h05, 8'h00, 8'h03, 8'h01, 1'b0);
        issue(balu_pkg::BALU_OP_SUB_CARRY_CONST, 8'h00, 8'h00, 8'h7F, 8'h20, 1'b0);
        idle();
    endtask
    task automatic t_logic();
        issue(balu_pkg::BALU_OP_AND, 8'hF0, 8'h00, 8'h0F, 8'hFF, 1'b0);
        issue(balu_pkg::BALU_OP_AND_CONST, 8'hC3, 8'h00, 8'h81, 8'h39, 1'b0);
        issue(balu_pkg::BALU_OP_OR, 8'h00, 8'h00, 8'h00, 8'hFD, 1'b0);
        issue(balu_pkg::BALU_OP_OR_CONST, 8'h12, 8'h00, 8'h80, 8'h08, 1'b0);
        issue(balu_pkg::BALU_OP_XOR, 8'hA5, 8'h00, 8'h5A, 8'h3E, 1'b0);
        issue(balu_pkg::BALU_OP_COM, 8'h5A, 8'h00, 8'h00, 8'h38, 1'b0);
        issue(balu_pkg::BALU_OP_COM, 8'hFF, 8'h00, 8'h00, 8'h00, 1'b0);
        issue(balu_pkg::BALU_OP_SET_MASK, 8'h01, 8'h00, 8'h80, 8'h30, 1'b0);
        issue(balu_pkg::BALU_OP_CLEAR_MASK, 8'h81, 8'h00, 8'h81, 8'h09, 1'b0);
        issue(balu_pkg::BALU_OP_TEST, 8'h80, 8'h00, 8'h00, 8'h3B, 1'b0);
        issue(balu_pkg::BALU_OP_ZERO_REG, 8'hE7, 8'h00, 8'h00, 8'h3D, 1'b0);
        idle();
    endtask
    task automatic t_word();
        issue(balu_pkg::BALU_OP_WORD_ADD_IMM, 8'hFF, 8'h00, 8'h01, 8'h20, 1'b0);
        issue(balu_pkg::BALU_OP_WORD_ADD_IMM, 8'hFF, 8'h7F, 8'h3F, 8'h00, 1'b0);
        issue(balu_pkg::BALU_OP_WORD_ADD_IMM, 8'hFF, 8'hFF, 8'h01, 8'h00, 1'b0);
        issue(balu_pkg::BALU_OP_WORD_SUB_IMM, 8'h00, 8'h00, 8'h01, 8'h20, 1'b0);
        issue(balu_pkg::BALU_OP_WORD_SUB_IMM, 8'h05, 8'h00, 8'h05, 8'hC0, 1'b0);
        issue(balu_pkg::BALU_OP_WORD_SUB_IMM, 8'h00, 8'h80, 8'h01, 8'h00, 1'b0);
        idle();
    endtask
    task automatic t_refuse();
        // a request in the busy cycle must not disturb the word result
        issue(balu_pkg::BALU_OP_WORD_SUB_IMM, 8'h10, 8'h34, 8'h20, 8'h00, 1'b1);
        idle();
        issue(balu_pkg::BALU_OP_ADD, 8'h01, 8'h00, 8'h01, 8'h00, 1'b0);
        issue(balu_pkg::BALU_OP_WORD_ADD_IMM, 8'hC0, 8'h12, 8'h40, 8'h01, 1'b0);
        idle();
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(negedge SYS_CLK_I);
        RST_N_I = 1'b1;
        chk({DONE_O, BUSY_O, WRITE_HIGH_O, 5'h00} | RESULT_O | FLAGS_O, 8'h00);
        t_add();
        t_sub();
        t_logic();
        t_word();
        t_refuse();
        end_sim();
    end
endmodule
